// [include/dat_pkg.sv]
// Shared constants, types and helpers for the DMA address-tracking block.
// Assumes a single clock and a synchronous, active-high reset at every user.
package dat_pkg;

  // Channel count, address width and link field widths.
  localparam int unsigned DAT_CHANNELS = 2;
  localparam int unsigned DAT_CH_W = 1;
  localparam int unsigned DAT_AW = 64;
  localparam int unsigned DAT_BEATS_W = 5;
  localparam int unsigned DAT_WB_AW = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets of channel 0, further channels following at the stride, and the shared channel-on register.
  localparam logic [11:0] DAT_OFS_SRC_LO = 12'h800;
  localparam logic [11:0] DAT_OFS_SRC_HI = 12'h804;
  localparam logic [11:0] DAT_OFS_DST_LO = 12'h808;
  localparam logic [11:0] DAT_OFS_DST_HI = 12'h80C;
  localparam logic [11:0] DAT_OFS_CHANNEL_CONTROL_LOW = 12'h818;
  localparam logic [11:0] DAT_OFS_CTL_HI = 12'h81C;
  localparam logic [11:0] DAT_CH_STRIDE = 12'h058;
  localparam logic [11:0] DAT_OFS_CHAN_ON = 12'hBA0;
  localparam logic [31:0] DAT_RST_WORD = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside the control words.
  localparam int unsigned DAT_SRC_HOLD_BIT = 10;
  localparam int unsigned DAT_DST_HOLD_BIT = 8;
  localparam int unsigned DAT_BLK_LSB = 0;
  localparam int unsigned DAT_BLK_W = 17;

  // Every beat moves one doubleword; addresses carry no byte offset.
  localparam int unsigned DAT_ALIGN_BITS = 2;
  localparam int unsigned DAT_BEAT_BYTES = 4;
  localparam int unsigned DAT_MAX_BEATS = 4;

  typedef enum logic [1:0] {DAT_ST_IDLE, DAT_ST_READ, DAT_ST_WRITE} dat_state_e;

  // Byte-lane merge of a bus write into a stored word.
  function automatic logic [31:0] dat_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      dat_merge[8*b +: 8] = sel[b] ? new_w[8*b +: 8] : old_w[8*b +: 8];
    end
  endfunction

  // Clears the byte offset so only doubleword addresses are issued.
  function automatic logic [DAT_AW-1:0] dat_align(input logic [DAT_AW-1:0] a);
    dat_align = {a[DAT_AW-1:DAT_ALIGN_BITS], {DAT_ALIGN_BITS{1'b0}}};
  endfunction

  // Picks the lowest requesting channel, or keeps the owner of an open offer.
  function automatic logic [DAT_CH_W-1:0] dat_pick(input logic [DAT_CHANNELS-1:0] req,
                                                   input logic busy,
                                                   input logic [DAT_CH_W-1:0] own);
    dat_pick = own;
    if (!busy) begin
      for (int c = DAT_CHANNELS - 1; c >= 0; c--) begin
        if (req[c]) begin
          dat_pick = DAT_CH_W'(c);
        end
      end
    end
  endfunction

endpackage

// [include/dat_fabric_if.sv]
// Command link between the DMA engine and the system fabric.
// Assumes both ends run on the same clock; the testbench ties them together.
interface dat_fabric_if;
  import dat_pkg::*;

  // Read command channel.
  logic rd_valid;
  logic rd_ready;
  logic [DAT_AW-1:0] rd_addr;
  logic [DAT_BEATS_W-1:0] rd_beats;
  logic [DAT_CH_W-1:0] rd_chan;

  // Write command channel.
  logic wr_valid;
  logic wr_ready;
  logic [DAT_AW-1:0] wr_addr;
  logic [DAT_BEATS_W-1:0] wr_beats;
  logic [DAT_CH_W-1:0] wr_chan;

  modport engine (
    output rd_valid, rd_addr, rd_beats, rd_chan,
    input rd_ready,
    output wr_valid, wr_addr, wr_beats, wr_chan,
    input wr_ready
  );

  modport fabric (
    input rd_valid, rd_addr, rd_beats, rd_chan,
    output rd_ready,
    input wr_valid, wr_addr, wr_beats, wr_chan,
    output wr_ready
  );
endinterface

// [logic/dat_addr_track.sv]
// One programmed/working/last-issued address triple for one direction of a channel.
// Assumes the caller gates descriptor loads to times when the channel is off.
module dat_addr_track
  import dat_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] sel_i,
  input wire logic desc_i,
  input wire logic [DAT_AW-1:0] desc_addr_i,
  input wire logic start_i,
  input wire logic adv_i,
  input wire logic hold_i,
  input wire logic [DAT_BLK_W-1:0] step_i,
  input wire logic on_i,
  output logic [DAT_AW-1:0] work_addr_o,
  output logic [DAT_AW-1:0] rb_o
);

  logic [DAT_AW-1:0] prog_q, prog_d;
  logic [DAT_AW-1:0] work_q, work_d;
  logic [DAT_AW-1:0] last_q, last_d;
  wire logic [DAT_AW-1:0] prog_al = dat_align(prog_q);

  ////////////////////////////////////////////////////////////////////////////
  // Programmed value: software halves or a chain descriptor, kept apart.
  always_comb begin
    prog_d = prog_q;
    if (desc_i) begin
      prog_d = desc_addr_i;
    end
    if (wr_lo_i) begin
      prog_d[31:0] = dat_merge(prog_q[31:0], wdata_i, sel_i);
    end
    if (wr_hi_i) begin
      prog_d[63:32] = dat_merge(prog_q[63:32], wdata_i, sel_i);
    end
  end

  // Working and last-issued addresses; a fabric issue records then advances.
  always_comb begin
    work_d = work_q;
    last_d = last_q;
    if (start_i) begin
      work_d = prog_al;
      last_d = prog_al;
    end else if (adv_i) begin
      last_d = work_q;
      if (!hold_i) begin
        work_d = work_q + DAT_AW'(step_i);
      end
    end
  end

  // State update.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_q <= '0;
      work_q <= '0;
      last_q <= '0;
    end else begin
      prog_q <= prog_d;
      work_q <= work_d;
      last_q <= last_d;
    end
  end

  // Read-back shows the last issued address while on, else the programmed one.
  assign work_addr_o = work_q;
  assign rb_o = on_i ? last_q : prog_q;

endmodule

// [logic/dat_fabric_end.sv]
// Fabric end of the command link: takes read and write commands and hands
// them to the user side through one holding stage per direction.
// Assumes the user side consumes a command on any cycle it asserts ready.
module dat_fabric_end
  import dat_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  dat_fabric_if.fabric link,
  output logic rd_cmd_valid_o,
  output logic [DAT_AW-1:0] rd_cmd_addr_o,
  output logic [DAT_BEATS_W-1:0] rd_cmd_beats_o,
  output logic [DAT_CH_W-1:0] rd_cmd_chan_o,
  input wire logic rd_cmd_ready_i,
  output logic wr_cmd_valid_o,
  output logic [DAT_AW-1:0] wr_cmd_addr_o,
  output logic [DAT_BEATS_W-1:0] wr_cmd_beats_o,
  output logic [DAT_CH_W-1:0] wr_cmd_chan_o,
  input wire logic wr_cmd_ready_i
);

  // A stage accepts when empty or when its content leaves this cycle.
  assign link.rd_ready = !rd_cmd_valid_o || rd_cmd_ready_i;
  assign link.wr_ready = !wr_cmd_valid_o || wr_cmd_ready_i;
  wire logic rd_take = link.rd_valid && link.rd_ready;
  wire logic wr_take = link.wr_valid && link.wr_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Holding stages.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_cmd_valid_o <= 1'b0;
      rd_cmd_addr_o <= '0;
      rd_cmd_beats_o <= '0;
      rd_cmd_chan_o <= '0;
      wr_cmd_valid_o <= 1'b0;
      wr_cmd_addr_o <= '0;
      wr_cmd_beats_o <= '0;
      wr_cmd_chan_o <= '0;
    end else begin
      if (link.rd_ready) begin
        rd_cmd_valid_o <= link.rd_valid;
      end
      if (rd_take) begin
        rd_cmd_addr_o <= link.rd_addr;
        rd_cmd_beats_o <= link.rd_beats;
        rd_cmd_chan_o <= link.rd_chan;
      end
      if (link.wr_ready) begin
        wr_cmd_valid_o <= link.wr_valid;
      end
      if (wr_take) begin
        wr_cmd_addr_o <= link.wr_addr;
        wr_cmd_beats_o <= link.wr_beats;
        wr_cmd_chan_o <= link.wr_chan;
      end
    end
  end

endmodule

// [logic/dat_engine_end.sv]
// Engine end: per-channel address registers, a Wishbone register slave,
// and a simple read-burst/write-burst sequencer that issues on the link.
// Assumes classic Wishbone from one master and a fabric that may stall.
module dat_engine_end
  import dat_pkg::*;
#(
  parameter int unsigned MAX_BEATS = DAT_MAX_BEATS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [DAT_WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic desc_load_i,
  input wire logic [DAT_CH_W-1:0] desc_chan_i,
  input wire logic [DAT_AW-1:0] desc_src_i,
  input wire logic [DAT_AW-1:0] desc_dst_i,
  output logic [DAT_CHANNELS-1:0] channel_on_o,
  dat_fabric_if.engine link
);

  // Refuse a zero burst length and burst lengths the beat field cannot carry.
  if (MAX_BEATS < 1 || MAX_BEATS >= (1 << DAT_BEATS_W)) begin : g_chk
    $error("MAX_BEATS out of range for the beat field");
  end

  localparam logic [DAT_BLK_W:0] MAX_BYTES = (DAT_BLK_W+1)'(MAX_BEATS * DAT_BEAT_BYTES);
  localparam logic [DAT_BLK_W:0] ROUND_UP = (DAT_BLK_W+1)'(DAT_BEAT_BYTES - 1);

  // True when a byte address names one register of the given channel.
  function automatic logic dat_hit(input logic [DAT_WB_AW-1:0] adr,
                                   input logic [11:0] ofs, input int c);
    dat_hit = adr == (ofs + 12'(c) * DAT_CH_STRIDE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the strobe, dropped the next cycle.
  logic ack_q;
  logic [31:0] rdat_q, rdat_d;
  logic [DAT_CHANNELS-1:0] on_q, on_d;
  wire logic wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic wb_wr = wb_req && wb_we_i;
  wire logic h_on = wb_adr_i == DAT_OFS_CHAN_ON;
  wire logic wr_on = wb_wr && h_on && wb_sel_i[0];
  logic [31:0] ch_rd [DAT_CHANNELS];

  // Link request, grant and payload per channel.
  logic [DAT_CHANNELS-1:0] rd_req, wr_req;
  logic [DAT_AW-1:0] src_work [DAT_CHANNELS];
  logic [DAT_AW-1:0] dst_work [DAT_CHANNELS];
  logic [DAT_BEATS_W-1:0] ch_beats [DAT_CHANNELS];
  logic rd_hold_q, wr_hold_q;
  logic [DAT_CH_W-1:0] rd_own_q, wr_own_q;
  wire logic [DAT_CH_W-1:0] rd_ch = dat_pick(rd_req, rd_hold_q, rd_own_q);
  wire logic [DAT_CH_W-1:0] wr_ch = dat_pick(wr_req, wr_hold_q, wr_own_q);

  // Offers on the link are muxed from the owning channel; the beat count is computed from its rem_q.
  assign link.rd_valid = rd_req[rd_ch];
  assign link.rd_addr = src_work[rd_ch];
  assign link.rd_beats = ch_beats[rd_ch];
  assign link.rd_chan = rd_ch;
  assign link.wr_valid = wr_req[wr_ch];
  assign link.wr_addr = dst_work[wr_ch];
  assign link.wr_beats = ch_beats[wr_ch];
  assign link.wr_chan = wr_ch;
  assign channel_on_o = on_q;

  ////////////////////////////////////////////////////////////////////////////
  // One channel: control words, sequencer and two address trackers.
  for (genvar c = 0; c < DAT_CHANNELS; c++) begin : g_ch
    wire logic h_slo = dat_hit(wb_adr_i, DAT_OFS_SRC_LO, c);
    wire logic h_shi = dat_hit(wb_adr_i, DAT_OFS_SRC_HI, c);
    wire logic h_dlo = dat_hit(wb_adr_i, DAT_OFS_DST_LO, c);
    wire logic h_dhi = dat_hit(wb_adr_i, DAT_OFS_DST_HI, c);
    wire logic h_cl = dat_hit(wb_adr_i, DAT_OFS_CHANNEL_CONTROL_LOW, c);
    wire logic h_chh = dat_hit(wb_adr_i, DAT_OFS_CTL_HI, c);
    logic [31:0] channel_control_low_q, ctl_hi_q;
    dat_state_e st_q, st_d;
    logic [DAT_BLK_W-1:0] rem_q, rem_d;
    logic [DAT_AW-1:0] src_rb, dst_rb;

    wire logic [DAT_BLK_W-1:0] blk = ctl_hi_q[DAT_BLK_LSB +: DAT_BLK_W];
    wire logic [DAT_BLK_W:0] rem_up = ({1'b0, rem_q} + ROUND_UP) >> DAT_ALIGN_BITS;
    wire logic [DAT_BLK_W:0] want = rem_up << DAT_ALIGN_BITS;
    wire logic [DAT_BLK_W-1:0] step = DAT_BLK_W'((want > MAX_BYTES) ? MAX_BYTES : want);
    wire logic rd_gnt = link.rd_valid && link.rd_ready && rd_ch == DAT_CH_W'(c);
    wire logic wr_gnt = link.wr_valid && link.wr_ready && wr_ch == DAT_CH_W'(c);
    wire logic start = wr_on && wb_dat_i[c] && !on_q[c];
    wire logic abort = wr_on && !wb_dat_i[c];
    wire logic last = st_q == DAT_ST_WRITE && wr_gnt && rem_q <= step;
    wire logic done = last || (start && blk == '0);
    wire logic desc = desc_load_i && desc_chan_i == DAT_CH_W'(c) && !on_q[c];
    wire logic src_hold = channel_control_low_q[DAT_SRC_HOLD_BIT];
    wire logic dst_hold = channel_control_low_q[DAT_DST_HOLD_BIT];

    assign ch_beats[c] = DAT_BEATS_W'(step >> DAT_ALIGN_BITS);
    assign rd_req[c] = st_q == DAT_ST_READ;
    assign wr_req[c] = st_q == DAT_ST_WRITE;
    // Completion clears the on flag even when software rewrites it in that cycle.
    assign on_d[c] = wr_on ? (wb_dat_i[c] && !done) : (on_q[c] && !done);

    // Sequencer: read burst, then the matching write burst, until done.
    always_comb begin
      st_d = st_q;
      rem_d = rem_q;
      unique case (st_q)
        DAT_ST_IDLE: begin
          if (start && blk != '0) begin
            st_d = DAT_ST_READ;
            rem_d = blk;
          end
        end
        DAT_ST_READ: begin
          if (rd_gnt) begin
            st_d = DAT_ST_WRITE;
          end
        end
        DAT_ST_WRITE: begin
          if (wr_gnt) begin
            st_d = last ? DAT_ST_IDLE : DAT_ST_READ;
            rem_d = last ? '0 : rem_q - step;
          end
        end
      endcase
      if (abort) begin
        st_d = DAT_ST_IDLE;
      end
    end

    // Control words and sequencer state.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        channel_control_low_q <= DAT_RST_WORD;
        ctl_hi_q <= DAT_RST_WORD;
        st_q <= DAT_ST_IDLE;
        rem_q <= '0;
      end else begin
        if (wb_wr && h_cl) begin
          channel_control_low_q <= dat_merge(channel_control_low_q, wb_dat_i, wb_sel_i);
        end
        if (wb_wr && h_chh) begin
          ctl_hi_q <= dat_merge(ctl_hi_q, wb_dat_i, wb_sel_i);
        end
        st_q <= st_d;
        rem_q <= rem_d;
      end
    end

    dat_addr_track u_src (
      .clk_i(clk_i), .rst_i(rst_i),
      .wr_lo_i(wb_wr && h_slo), .wr_hi_i(wb_wr && h_shi),
      .wdata_i(wb_dat_i), .sel_i(wb_sel_i),
      .desc_i(desc), .desc_addr_i(desc_src_i),
      .start_i(start), .adv_i(rd_gnt), .hold_i(src_hold), .step_i(step),
      .on_i(on_q[c]), .work_addr_o(src_work[c]), .rb_o(src_rb)
    );

    dat_addr_track u_dst (
      .clk_i(clk_i), .rst_i(rst_i),
      .wr_lo_i(wb_wr && h_dlo), .wr_hi_i(wb_wr && h_dhi),
      .wdata_i(wb_dat_i), .sel_i(wb_sel_i),
      .desc_i(desc), .desc_addr_i(desc_dst_i),
      .start_i(start), .adv_i(wr_gnt), .hold_i(dst_hold), .step_i(step),
      .on_i(on_q[c]), .work_addr_o(dst_work[c]), .rb_o(dst_rb)
    );

    // Read data of this channel, zero when no register of it is addressed.
    assign ch_rd[c] = ({32{h_slo}} & src_rb[31:0]) | ({32{h_shi}} & src_rb[63:32])
                    | ({32{h_dlo}} & dst_rb[31:0]) | ({32{h_dhi}} & dst_rb[63:32])
                    | ({32{h_cl}} & channel_control_low_q) | ({32{h_chh}} & ctl_hi_q);
  end

  // Read mux; an unmapped address answers with zero.
  always_comb begin
    rdat_d = h_on ? 32'(on_q) : DAT_RST_WORD;
    for (int c = 0; c < DAT_CHANNELS; c++) begin
      rdat_d = rdat_d | ch_rd[c];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer, channel-on flags and the link offer locks.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= DAT_RST_WORD;
      on_q <= '0;
      rd_hold_q <= 1'b0;
      wr_hold_q <= 1'b0;
      rd_own_q <= '0;
      wr_own_q <= '0;
    end else begin
      ack_q <= wb_req;
      if (wb_req) begin
        rdat_q <= rdat_d;
      end
      on_q <= on_d;
      rd_hold_q <= link.rd_valid && !link.rd_ready;
      wr_hold_q <= link.wr_valid && !link.wr_ready;
      rd_own_q <= rd_ch;
      wr_own_q <= wr_ch;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule

// [tb/dat_link_monitor.sv]
// Checker for the engine-to-fabric command link.
// Assumes one clock and a synchronous, active-high reset.
module dat_link_monitor
  import dat_pkg::*;
#(
  parameter int unsigned MAX_BEATS = DAT_MAX_BEATS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [DAT_AW-1:0] rd_addr,
  input wire logic [DAT_BEATS_W-1:0] rd_beats,
  input wire logic [DAT_CH_W-1:0] rd_chan,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [DAT_AW-1:0] wr_addr,
  input wire logic [DAT_BEATS_W-1:0] wr_beats,
  input wire logic [DAT_CH_W-1:0] wr_chan
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DAT_CHANNELS-1:0] pend_q;
  logic [DAT_BEATS_W-1:0] beats_q [DAT_CHANNELS];

  ////////////////////////////////////////////////////////////////////////////
  // Remembers per channel a taken read burst that still owes its write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= '0;
      beats_q <= '{default: '0};
    end else begin
      if (rd_valid && rd_ready) begin
        pend_q[rd_chan] <= 1'b1;
        beats_q[rd_chan] <= rd_beats;
      end
      if (wr_valid && wr_ready) begin
        pend_q[wr_chan] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence rd_stall_s;
    rd_valid && !rd_ready;
  endsequence
  sequence wr_stall_s;
    wr_valid && !wr_ready;
  endsequence
  sequence rd_take_s;
    rd_valid && rd_ready;
  endsequence

  // Offers stand still until taken, and carry only whole doublewords.
  a_rd_offer_held: assert property (
    rd_stall_s |=> rd_valid && $stable({rd_addr, rd_beats, rd_chan}))
    else $error("read offer changed while stalled");
  a_wr_offer_held: assert property (
    wr_stall_s |=> wr_valid && $stable({wr_addr, wr_beats, wr_chan}))
    else $error("write offer changed while stalled");
  a_rd_addr_aligned: assert property (rd_valid |-> rd_addr[1:0] == 2'b00)
    else $error("read address not doubleword aligned");
  a_wr_addr_aligned: assert property (wr_valid |-> wr_addr[1:0] == 2'b00)
    else $error("write address not doubleword aligned");
  a_rd_beats_range: assert property (
    rd_valid |-> rd_beats != 0 && rd_beats <= MAX_BEATS)
    else $error("read burst length out of range");
  // Reads and writes of one channel alternate with equal burst lengths.
  a_rd_after_write: assert property (rd_take_s |-> !pend_q[rd_chan])
    else $error("second read burst before its write");
  a_wr_after_read: assert property (wr_valid |-> pend_q[wr_chan])
    else $error("write burst offered without a read");
  a_wr_beats_match: assert property (wr_valid |-> wr_beats == beats_q[wr_chan])
    else $error("write burst length differs from read");
  a_wr_taken_bound: assert property ($rose(pend_q[0]) |-> ##[0:300] !pend_q[0])
    else $error("write burst of channel zero never taken");
endmodule

// [tb/tb.sv]
// Testbench joining the engine end and the fabric end of the command link.
// Assumes the package and the link interface are compiled first.
module tb
  import dat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MAXB = 3;
  logic clk_i = 0, rst_i = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack;
  logic desc_ld = 0, desc_ch = 0, rd_rdy = 0, wr_rdy = 0, freeze = 0;
  logic shold, dhold, cur_c, rcv, wcv, rch, wch;
  logic [11:0] wb_adr = '0;
  logic [3:0] wb_sel = '0;
  logic [31:0] wb_wd = '0, wb_rd;
  logic [63:0] desc_s = '0, desc_d = '0, src_p, dst_p, rca, wca;
  logic [4:0] rcb, wcb;
  logic [1:0] ch_on;
  int miscompares = 0, tests_run = 0, cycles = 0, nbytes, rd_seen, wr_seen;
  int rd_tk [2], wr_tk [2];

  ////////////////////////////////////////////////////////////////////////////
  // Clock, the two link ends and the link checker.
  always #4 clk_i = ~clk_i;
  dat_fabric_if lnk();
  dat_engine_end #(.MAX_BEATS(MAXB)) u_dat_engine_end (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
    .desc_load_i(desc_ld), .desc_chan_i(desc_ch), .desc_src_i(desc_s),
    .desc_dst_i(desc_d), .channel_on_o(ch_on), .link(lnk.engine));
  dat_fabric_end u_dat_fabric_end (.clk_i(clk_i), .rst_i(rst_i), .link(lnk.fabric),
    .rd_cmd_valid_o(rcv), .rd_cmd_addr_o(rca), .rd_cmd_beats_o(rcb), .rd_cmd_chan_o(rch),
    .rd_cmd_ready_i(rd_rdy), .wr_cmd_valid_o(wcv), .wr_cmd_addr_o(wca),
    .wr_cmd_beats_o(wcb), .wr_cmd_chan_o(wch), .wr_cmd_ready_i(wr_rdy));
  dat_link_monitor #(.MAX_BEATS(MAXB)) u_dat_link_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .rd_valid(lnk.rd_valid), .rd_ready(lnk.rd_ready), .rd_addr(lnk.rd_addr),
    .rd_beats(lnk.rd_beats), .rd_chan(lnk.rd_chan), .wr_valid(lnk.wr_valid),
    .wr_ready(lnk.wr_ready), .wr_addr(lnk.wr_addr), .wr_beats(lnk.wr_beats),
    .wr_chan(lnk.wr_chan));

  ////////////////////////////////////////////////////////////////////////////
  // Expected burst address, burst length and register offset.
  function automatic logic [63:0] ex_addr(input logic [63:0] a, input logic h, input int k);
    return {a[63:2], 2'b00} + (h ? 64'h0 : 64'(4 * MAXB * k));
  endfunction
  function automatic logic [4:0] ex_beats(input int k);
    int t;
    t = (nbytes + 3) / 4 - MAXB * k;
    return 5'(t < MAXB ? t : MAXB);
  endfunction
  function automatic logic [11:0] ofs(input logic [11:0] o, input int c);
    return o + 12'(c) * DAT_CH_STRIDE;
  endfunction

  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic complete_run();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One classic Wishbone cycle, held until ack is sampled high.
  task automatic wb_io(input logic we, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wd <= d;
    wb_sel <= s;
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    r = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Cuts a hang short.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      complete_run();
    end
  end

  // Stalls the fabric at random, counts link takes, checks every command.
  always @(posedge clk_i) begin
    rd_rdy <= !freeze && ($urandom_range(3) != 0);
    wr_rdy <= !freeze && ($urandom_range(3) != 0);
    if (lnk.rd_valid === 1'b1 && lnk.rd_ready === 1'b1) begin
      rd_tk[lnk.rd_chan]++;
    end
    if (lnk.wr_valid === 1'b1 && lnk.wr_ready === 1'b1) begin
      wr_tk[lnk.wr_chan]++;
    end
    if (rcv === 1'b1 && rd_rdy) begin
      chk("rd_addr", ex_addr(src_p, shold, rd_seen), rca);
      chk("rd_beats_chan", 64'({ex_beats(rd_seen), cur_c}), 64'({rcb, rch}));
      rd_seen++;
    end
    if (wcv === 1'b1 && wr_rdy) begin
      chk("wr_addr", ex_addr(dst_p, dhold, wr_seen), wca);
      chk("wr_beats_chan", 64'({ex_beats(wr_seen), cur_c}), 64'({wcb, wch}));
      wr_seen++;
    end
  end

  // One block on channel c; mode bits 0 and 1 are the hold bits.
  task automatic run(input int c, input int mode);
    logic [127:0] sd;
    logic [63:0] es, ed;
    logic [31:0] r;
    int nb;
    sd = {$urandom, $urandom, $urandom, $urandom};
    if (mode == 0) begin
      sd[31:0] = 32'hFFFF_FFF6;
    end
    {dst_p, src_p} = sd;
    cur_c = 1'(c);
    shold = mode[0];
    dhold = mode[1];
    nbytes = (mode == 4) ? 0 : 1 + $urandom_range(79);
    nb = ((nbytes + 3) / 4 + MAXB - 1) / MAXB;
    rd_seen = 0;
    wr_seen = 0;
    rd_tk[c] = 0;
    wr_tk[c] = 0;
    desc_ch <= 1'(c);
    desc_s <= src_p;
    desc_d <= dst_p;
    if (mode == 5) begin
      desc_ld <= 1'b1;
      @(posedge clk_i);
      desc_ld <= 1'b0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        wb_io(1'b1, ofs(DAT_OFS_SRC_LO + 12'(4 * k), c), sd[32 * k +: 32], 4'hF, r);
      end
    end
    wb_io(1'b1, ofs(DAT_OFS_CHANNEL_CONTROL_LOW, c), (32'(shold) << DAT_SRC_HOLD_BIT)
          | (32'(dhold) << DAT_DST_HOLD_BIT), 4'hF, r);
    wb_io(1'b1, ofs(DAT_OFS_CTL_HI, c), 32'(nbytes), 4'hF, r);
    wb_io(1'b1, DAT_OFS_CHAN_ON, 32'(1) << c, 4'h1, r);
    chk("channel_on", 64'(nbytes != 0), 64'(ch_on[c]));
    if (nb >= 4) begin
      while (rd_tk[c] < 2) begin
        @(posedge clk_i);
      end
      // Stall the fabric so the read-back is a steady progress marker.
      freeze <= 1'b1;
      repeat (6) @(posedge clk_i);
      for (int k = 0; k < 4; k++) begin
        wb_io(1'b0, ofs(DAT_OFS_SRC_LO + 12'(4 * k), c), 32'h0, 4'hF, r);
        es = ex_addr(src_p, shold, rd_tk[c] - 1);
        ed = (wr_tk[c] == 0) ? {dst_p[63:2], 2'b00} : ex_addr(dst_p, dhold, wr_tk[c] - 1);
        chk("run_readback", 64'(32'((k < 2 ? es : ed) >> (32 * (k % 2)))), 64'(r));
      end
      wb_io(1'b0, DAT_OFS_CHAN_ON, 32'h0, 4'hF, r);
      chk("on_register", 64'(32'(1) << c), 64'(r));
      desc_s <= ~src_p;
      desc_d <= ~dst_p;
      desc_ld <= 1'b1;
      @(posedge clk_i);
      desc_ld <= 1'b0;
      freeze <= 1'b0;
    end
    while (ch_on[c] !== 1'b0 || rcv !== 1'b0 || wcv !== 1'b0) begin
      @(posedge clk_i);
    end
    @(posedge clk_i);
    chk("read_bursts", 64'(nb), 64'(rd_seen));
    chk("write_bursts", 64'(nb), 64'(wr_seen));
    for (int k = 0; k < 4; k++) begin
      wb_io(1'b0, ofs(DAT_OFS_SRC_LO + 12'(4 * k), c), 32'h0, 4'hF, r);
      chk("idle_readback", 64'(sd[32 * k +: 32]), 64'(r));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, an unmapped place, byte lanes, then random blocks.
  initial begin
    logic [31:0] r;
    void'($urandom(32'h5104));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int k = 0; k < 8; k++) begin
      wb_io(1'b0, ofs(DAT_OFS_SRC_LO + 12'(4 * (k % 4)), k / 4), 32'h0, 4'hF, r);
      chk("reset_value", 64'h0, 64'(r));
    end
    wb_io(1'b1, 12'hFFC, 32'hFFFF_FFFF, 4'hF, r);
    wb_io(1'b0, 12'hFFC, 32'h0, 4'hF, r);
    chk("unmapped", 64'h0, 64'(r));
    wb_io(1'b1, ofs(DAT_OFS_DST_HI, 1), 32'hFFFF_FFFF, 4'hF, r);
    wb_io(1'b1, ofs(DAT_OFS_DST_HI, 1), 32'h1234_5678, 4'h5, r);
    wb_io(1'b0, ofs(DAT_OFS_DST_HI, 1), 32'h0, 4'hF, r);
    chk("byte_lanes", 64'h0000_0000_FF34_FF78, 64'(r));
    for (int i = 0; i < 12; i++) begin
      run(int'($urandom_range(1)), i % 6);
    end
    complete_run();
  end
endmodule
